// >>> src/himsel_pkg.sv
package himsel_pkg;
  localparam logic MODE_SPI = 1'b0;
  localparam logic MODE_SDIO = 1'b1;
  localparam logic STRAP_SDIO_LEVEL = 1'b1;
  localparam int SYS_CLK_HZ = 20000000;
  localparam int LINK_CLK_DIV = 4;
  localparam int RST_HOLD_CYCLES = 8;
  localparam int WAKE_LEAD_CYCLES = 4;
  localparam logic [1:0] CS_IDLE = 2'h3;
  typedef enum logic [2:0] {
    HIMSEL_OFF_TYPE = 3'b001,
    HIMSEL_AWAKE_TYPE = 3'b010,
    HIMSEL_SLEEP_TYPE = 3'b100
  } himsel_pwr_type;
endpackage

// >>> src/himsel_if.sv
interface himsel_if;
  logic rst_low;
  logic strap_o;
  logic strap_oe;
  logic strap_dev_o;
  logic strap_dev_oe;
  logic link_clk;
  logic cmd_mosi;
  logic dat0_miso;
  logic dat0_oe;
  logic dat1_o;
  logic dat1_oe;
  logic dat3_cs;
  logic wake_request_input;
  logic duplicate_interrupt_pin;
  logic dup_oe;
  wire strap_level = strap_oe ? strap_o : (strap_dev_oe ? strap_dev_o : 1'b0);
  modport device_end (
    input rst_low, strap_o, strap_oe, link_clk, cmd_mosi, dat3_cs, wake_request_input,
    output strap_dev_o, strap_dev_oe, dat0_miso, dat0_oe, dat1_o, dat1_oe,
    output duplicate_interrupt_pin, dup_oe
  );
  modport host_end (
    output rst_low, strap_o, strap_oe, link_clk, cmd_mosi, dat3_cs, wake_request_input,
    input strap_dev_o, strap_dev_oe, dat0_miso, dat0_oe, dat1_o, dat1_oe,
    input duplicate_interrupt_pin, dup_oe
  );
endinterface

// >>> src/himsel_device.sv
// Behaviour
// - Strap sampled at reset rising edge
// - Strap high gives SDIO, else SPI
// - Strap ignored in SPI, data2 in SDIO
// - SPI: data1 pin is interrupt out
// - Host keeps link clock within limits
// - Host uses wake input to wake
// - Sleep only while wake input low
// - Wake pin becomes GPIO input without power save
// - Optional interrupt copy, else GPIO
// - Reset release starts full start-up
// - Host wakes device before transactions
module himsel_device
  import himsel_pkg::*;
(
  // System
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Link pins
  himsel_if.device_end LINK,
  // Core side
  input wire logic IRQ_REQ,
  input wire logic MISO_DATA,
  input wire logic DAT_OUT,
  input wire logic DAT_OE,
  input wire logic SLEEP_REQ,
  input wire logic POWER_SAVE_EN,
  input wire logic DUP_IRQ_EN,
  input wire logic GPIO_WAKE_O,
  input wire logic GPIO_WAKE_OE,
  input wire logic GPIO_DUP_O,
  input wire logic GPIO_DUP_OE,
  output logic MODE_SDIO_OUT,
  output logic STARTUP_PULSE,
  output logic AWAKE,
  output logic WAKE_EVENT,
  output logic LINK_CLK_RISE,
  output logic LINK_CLK_FALL,
  output logic MOSI_SYNC,
  output logic CS_LOW_SYNC,
  output logic GPIO_WAKE_IN
);
  import himsel_pkg::*;

  logic [1:0] rst_sync_reg;
  logic [1:0] strap_sync_reg;
  logic [1:0] clk_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] wake_sync_reg;
  logic clk_prev_reg;
  logic wake_prev_reg;
  logic rst_prev_reg;
  logic strap_prev_reg;
  logic mode_reg;
  logic mode_next;
  logic start_reg;
  logic miso_reg;
  logic dat1_reg;
  logic dup_reg;
  himsel_pwr_type pwr_reg;
  himsel_pwr_type pwr_next;

  wire rst_released = rst_sync_reg[1];
  wire rst_rise = rst_released & ~rst_prev_reg;
  wire strap_level = LINK.strap_oe ? LINK.strap_o : 1'b0;
  wire wake_level = wake_sync_reg[1];
  wire wake_rise = wake_level & ~wake_prev_reg;
  wire wake_as_gpio = ~POWER_SAVE_EN;
  wire sleep_ok = SLEEP_REQ & ~wake_level & POWER_SAVE_EN;

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rst_sync_reg <= 2'h0;
      strap_sync_reg <= 2'h0;
      clk_sync_reg <= 2'h0;
      mosi_sync_reg <= 2'h0;
      cs_sync_reg <= CS_IDLE;
      wake_sync_reg <= 2'h0;
      clk_prev_reg <= 1'b0;
      wake_prev_reg <= 1'b0;
      rst_prev_reg <= 1'b0;
      strap_prev_reg <= 1'b0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], LINK.rst_low};
      strap_sync_reg <= {strap_sync_reg[0], strap_level};
      clk_sync_reg <= {clk_sync_reg[0], LINK.link_clk};
      mosi_sync_reg <= {mosi_sync_reg[0], LINK.cmd_mosi};
      cs_sync_reg <= {cs_sync_reg[0], LINK.dat3_cs};
      wake_sync_reg <= {wake_sync_reg[0], LINK.wake_request_input};
      clk_prev_reg <= clk_sync_reg[1];
      wake_prev_reg <= wake_level;
      rst_prev_reg <= rst_released;
      strap_prev_reg <= strap_sync_reg[1];
    end
  end

  // Mode capture on the link reset release, then frozen
  // Strap taken one sample older than the synced reset: the level before release
  always_comb
  begin
    mode_next = mode_reg;
    if (rst_rise)
    begin
      mode_next = (strap_prev_reg == STRAP_SDIO_LEVEL) ? MODE_SDIO : MODE_SPI;
    end
  end

  always_comb
  begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      HIMSEL_OFF_TYPE:
        if (rst_rise)
        begin
          pwr_next = HIMSEL_AWAKE_TYPE;
        end
      HIMSEL_AWAKE_TYPE:
        if (!rst_released)
        begin
          pwr_next = HIMSEL_OFF_TYPE;
        end
        else if (sleep_ok)
        begin
          pwr_next = HIMSEL_SLEEP_TYPE;
        end
      HIMSEL_SLEEP_TYPE:
        if (!rst_released)
        begin
          pwr_next = HIMSEL_OFF_TYPE;
        end
        else if (wake_level)
        begin
          pwr_next = HIMSEL_AWAKE_TYPE;
        end
      default:
        pwr_next = HIMSEL_OFF_TYPE;
    endcase
  end

  wire irq_line = IRQ_REQ & (pwr_reg == HIMSEL_AWAKE_TYPE);
  wire spi_mode = (mode_reg == MODE_SPI);
  wire cs_active = ~cs_sync_reg[1];

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mode_reg <= MODE_SPI;
      pwr_reg <= HIMSEL_OFF_TYPE;
      start_reg <= 1'b0;
      miso_reg <= 1'b0;
      dat1_reg <= 1'b0;
      dup_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      pwr_reg <= pwr_next;
      start_reg <= rst_rise;
      miso_reg <= spi_mode ? MISO_DATA : DAT_OUT;
      dat1_reg <= spi_mode ? irq_line : DAT_OUT;
      dup_reg <= DUP_IRQ_EN ? irq_line : GPIO_DUP_O;
    end
  end

  // Strap pin: never driven in SPI; data line 2 in SDIO
  assign LINK.strap_dev_o = DAT_OUT;
  assign LINK.strap_dev_oe = (mode_reg == MODE_SDIO) & rst_released & DAT_OE;
  assign LINK.dat0_miso = miso_reg;
  assign LINK.dat0_oe = spi_mode ? (cs_active & rst_released) : (DAT_OE & rst_released);
  assign LINK.dat1_o = dat1_reg;
  assign LINK.dat1_oe = rst_released & (spi_mode | DAT_OE);
  assign LINK.duplicate_interrupt_pin = dup_reg;
  assign LINK.dup_oe = DUP_IRQ_EN | GPIO_DUP_OE;

  assign MODE_SDIO_OUT = mode_reg;
  assign STARTUP_PULSE = start_reg;
  assign AWAKE = (pwr_reg == HIMSEL_AWAKE_TYPE);
  assign WAKE_EVENT = wake_rise & ~wake_as_gpio;
  assign LINK_CLK_RISE = clk_sync_reg[1] & ~clk_prev_reg;
  assign LINK_CLK_FALL = ~clk_sync_reg[1] & clk_prev_reg;
  assign MOSI_SYNC = mosi_sync_reg[1];
  assign CS_LOW_SYNC = cs_active;
  assign GPIO_WAKE_IN = wake_as_gpio & wake_level;
  logic unused_gpio_wake;
  assign unused_gpio_wake = GPIO_WAKE_O ^ GPIO_WAKE_OE;
endmodule // himsel_device

// >>> src/himsel_host.sv
module himsel_host
  import himsel_pkg::*;
#(
  parameter int CLK_DIV = LINK_CLK_DIV
)
(
  // System
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Link pins
  himsel_if.host_end LINK,
  // User side
  input wire logic RESET_REQ,
  input wire logic WANT_SDIO,
  input wire logic ALLOW_SLEEP,
  input wire logic XFER_REQ,
  input wire logic MOSI_BIT,
  input wire logic CS_ASSERT,
  output logic RESET_DONE,
  output logic XFER_GO,
  output logic IRQ_SEEN,
  output logic MISO_BIT
);
  import himsel_pkg::*;

  logic [7:0] div_reg;
  logic clk_reg;
  logic [7:0] hold_reg;
  logic rst_out_reg;
  logic [7:0] lead_reg;
  logic wake_reg;
  logic mosi_reg;
  logic cs_reg;
  logic [1:0] irq_sync_reg;
  logic [1:0] miso_sync_reg;

  wire div_wrap = (div_reg == 8'(CLK_DIV - 1));
  wire hold_done = (hold_reg == 8'(RST_HOLD_CYCLES));
  wire lead_done = (lead_reg == 8'(WAKE_LEAD_CYCLES));
  wire want_wake = XFER_REQ | ~ALLOW_SLEEP;

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      div_reg <= 8'h0;
      clk_reg <= 1'b0;
      hold_reg <= 8'h0;
      rst_out_reg <= 1'b0;
      lead_reg <= 8'h0;
      wake_reg <= 1'b0;
      mosi_reg <= 1'b0;
      cs_reg <= 1'b1;
      irq_sync_reg <= 2'h0;
      miso_sync_reg <= 2'h0;
    end
    else
    begin
      div_reg <= div_wrap ? 8'h0 : div_reg + 8'h1;
      clk_reg <= div_wrap ? ~clk_reg : clk_reg;
      hold_reg <= RESET_REQ ? 8'h0 : (hold_done ? hold_reg : hold_reg + 8'h1);
      rst_out_reg <= ~RESET_REQ & hold_done;
      wake_reg <= want_wake;
      lead_reg <= !wake_reg ? 8'h0 : (lead_done ? lead_reg : lead_reg + 8'h1);
      mosi_reg <= MOSI_BIT;
      cs_reg <= ~(CS_ASSERT & XFER_GO);
      irq_sync_reg <= {irq_sync_reg[0], LINK.dat1_o & LINK.dat1_oe};
      miso_sync_reg <= {miso_sync_reg[0], LINK.dat0_miso & LINK.dat0_oe};
    end
  end

  assign LINK.link_clk = clk_reg;
  assign LINK.rst_low = rst_out_reg;
  assign LINK.strap_o = WANT_SDIO ? STRAP_SDIO_LEVEL : ~STRAP_SDIO_LEVEL;
  assign LINK.strap_oe = ~rst_out_reg;
  assign LINK.cmd_mosi = mosi_reg;
  assign LINK.dat3_cs = cs_reg;
  assign LINK.wake_request_input = wake_reg;
  assign RESET_DONE = rst_out_reg;
  assign XFER_GO = rst_out_reg & lead_done & XFER_REQ;
  assign IRQ_SEEN = irq_sync_reg[1];
  assign MISO_BIT = miso_sync_reg[1];
endmodule // himsel_host

// >>> tb/himsel_checker.sv
module himsel_checker (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Link
  input wire logic rst_low,
  input wire logic strap_o,
  input wire logic strap_oe,
  input wire logic strap_dev_oe,
  input wire logic link_clk,
  input wire logic dat0_oe,
  input wire logic dat1_oe,
  input wire logic dat3_cs,
  input wire logic wake_request_input
);
  logic mode_reg;
  logic [3:0] up_reg;
  wire up_ok = up_reg == 4'hf;
  wire spi_ok = up_ok && !mode_reg;
  // Strap level last seen while reset held
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      mode_reg <= 1'b0;
    else if (!rst_low)
      mode_reg <= strap_oe & strap_o;
  end
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      up_reg <= 4'h0;
    else
      up_reg <= !rst_low ? 4'h0 : (up_ok ? up_reg : up_reg + 4'h1);
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  property p_release; $rose(rst_low) |-> !strap_oe; endproperty
  a_release: assert property (p_release) else $error("strap held");
  property p_hold; $fell(rst_low) |-> !rst_low [*8]; endproperty
  a_hold: assert property (p_hold) else $error("reset short");
  property p_spi_strap; spi_ok |-> !strap_dev_oe; endproperty
  a_spi_strap: assert property (p_spi_strap) else $error("strap driven");
  property p_spi_irq; spi_ok |-> dat1_oe; endproperty
  a_spi_irq: assert property (p_spi_irq) else $error("irq off");
  property p_miso; (spi_ok && dat3_cs) [*5] |-> !dat0_oe; endproperty
  a_miso: assert property (p_miso) else $error("miso driven");
  property p_clk; $changed(link_clk) |=> $stable(link_clk); endproperty
  a_clk: assert property (p_clk) else $error("clock fast");
  property p_wake; spi_ok && $fell(dat3_cs) |-> $past(wake_request_input, 4); endproperty
  a_wake: assert property (p_wake) else $error("no wake lead");
  property p_cs; !rst_low |-> dat3_cs; endproperty
  a_cs: assert property (p_cs) else $error("cs in reset");
endmodule // himsel_checker

// >>> tb/tb_host_interface_mode_select.sv
module tb_host_interface_mode_select import himsel_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rstn = 1'b0, rst_req = 1'b0, want_sdio = 1'b0, allow_sleep = 1'b0;
  logic xfer_req = 1'b0, mosi_bit = 1'b0, cs_assert = 1'b0, irq_req = 1'b0, miso_data = 1'b0;
  logic sleep_req = 1'b0, ps_en = 1'b1, dup_en = 1'b0, gdup_o = 1'b0, gdup_oe = 1'b0;
  logic mode_sdio, startup, awake, mosi_sync, cs_low_sync, gpio_wake_in;
  logic rst_done, xfer_go, irq_seen, miso_bit;
  logic dat_out = 1'b0, dat_oe = 1'b0, wake_ev, lk_rise, lk_fall;
  int n_errors = 0, tests_run = 0, seed = 72, cyc = 0, n;
  int n_rise = 0, n_fall = 0, n_wake = 0;
  himsel_if lk ();
  himsel_host i_himsel_host (.SYS_CLK(sys_clk), .RSTN(rstn), .LINK(lk.host_end),
    .RESET_REQ(rst_req), .WANT_SDIO(want_sdio), .ALLOW_SLEEP(allow_sleep), .XFER_REQ(xfer_req),
    .MOSI_BIT(mosi_bit), .CS_ASSERT(cs_assert), .RESET_DONE(rst_done), .XFER_GO(xfer_go),
    .IRQ_SEEN(irq_seen), .MISO_BIT(miso_bit));
  himsel_device i_himsel_device (.SYS_CLK(sys_clk), .RSTN(rstn), .LINK(lk.device_end),
    .IRQ_REQ(irq_req), .MISO_DATA(miso_data), .DAT_OUT(dat_out), .DAT_OE(dat_oe),
    .SLEEP_REQ(sleep_req), .POWER_SAVE_EN(ps_en), .DUP_IRQ_EN(dup_en), .GPIO_WAKE_O(1'b0),
    .GPIO_WAKE_OE(1'b0), .GPIO_DUP_O(gdup_o), .GPIO_DUP_OE(gdup_oe),
    .MODE_SDIO_OUT(mode_sdio), .STARTUP_PULSE(startup), .AWAKE(awake), .WAKE_EVENT(wake_ev),
    .LINK_CLK_RISE(lk_rise), .LINK_CLK_FALL(lk_fall), .MOSI_SYNC(mosi_sync),
    .CS_LOW_SYNC(cs_low_sync),
    .GPIO_WAKE_IN(gpio_wake_in));
  himsel_checker i_himsel_checker (.SYS_CLK(sys_clk), .RSTN(rstn), .rst_low(lk.rst_low),
    .strap_o(lk.strap_o), .strap_oe(lk.strap_oe), .strap_dev_oe(lk.strap_dev_oe),
    .link_clk(lk.link_clk), .dat0_oe(lk.dat0_oe), .dat1_oe(lk.dat1_oe),
    .dat3_cs(lk.dat3_cs), .wake_request_input(lk.wake_request_input));
  initial forever #25 sys_clk = ~sys_clk;
  // One-cycle pulses counted where they are settled
  always @(negedge sys_clk)
  begin
    n_rise += lk_rise;
    n_fall += lk_fall;
    n_wake += wake_ev;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic e, input logic s);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  // Host reset with a strap level, then the strap moves afterwards
  task automatic hreset(input logic sd);
    @(posedge sys_clk);
    rst_req <= 1'b1;
    want_sdio <= sd;
    @(posedge sys_clk);
    rst_req <= 1'b0;
    for (n = 0; n < 60 && startup !== 1'b1; n++) tick(1);
    chk("startup", 1'b1, startup);
    chk("mode", sd == STRAP_SDIO_LEVEL, mode_sdio);
    @(posedge sys_clk);
    want_sdio <= ~sd;
    n_rise = 0;
    n_fall = 0;
    tick(32);
    chk("mode held", sd == STRAP_SDIO_LEVEL, mode_sdio);
    chk("link rises", 1'b1, n_rise == 32 / (2 * LINK_CLK_DIV));
    chk("link falls", 1'b1, n_fall == 32 / (2 * LINK_CLK_DIV));
    @(posedge sys_clk);
    dat_oe <= 1'b1;
    dat_out <= 1'($random(seed));
    tick(2);
    chk("data2 drive", sd == STRAP_SDIO_LEVEL, lk.strap_dev_oe);
    chk("data2 value", dat_out, lk.strap_dev_o);
    @(posedge sys_clk);
    dat_oe <= 1'b0;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) hreset(i == 4 ? 1'b0 : (i < 2 ? i[0] : 1'($random(seed))));
    $display("mode select done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      {mosi_bit, miso_data, irq_req, dup_en, gdup_o, dat_out, dat_oe} <= 7'($random(seed));
      gdup_oe <= 1'b1;
      cs_assert <= 1'b1;
      xfer_req <= 1'b1;
      tick(10);
      chk("strap free", 1'b0, lk.strap_dev_oe);
      chk("mosi", mosi_bit, mosi_sync);
      chk("cs", 1'b1, cs_low_sync);
      chk("miso", miso_data, miso_bit);
      chk("irq", irq_req, irq_seen);
      chk("dup", dup_en ? irq_req : gdup_o, lk.duplicate_interrupt_pin);
    end
    @(posedge sys_clk);
    cs_assert <= 1'b0;
    xfer_req <= 1'b0;
    sleep_req <= 1'b1;
    tick(10);
    $display("spi pins done");
    chk("awake", 1'b1, awake);
    @(posedge sys_clk);
    allow_sleep <= 1'b1;
    tick(10);
    chk("asleep", 1'b0, awake);
    @(posedge sys_clk);
    allow_sleep <= 1'b0;
    xfer_req <= 1'b1;
    n_wake = 0;
    for (n = 0; n < 40 && xfer_go !== 1'b1; n++) tick(1);
    chk("wake event", 1'b1, n_wake == 1);
    chk("go", 1'b1, xfer_go);
    chk("lead", 1'b1, n >= WAKE_LEAD_CYCLES);
    chk("woken", 1'b1, awake);
    $display("wake done");
    for (int i = 0; i < 3; i++)
    begin
      @(posedge sys_clk);
      {ps_en, sleep_req, xfer_req} <= 3'h0;
      allow_sleep <= i[0];
      tick(8);
      chk("gpio wake", !i[0], gpio_wake_in);
    end
    $display("gpio done");
    finish_test();
  end
endmodule // tb_host_interface_mode_select
